// file: rtl/spi_slave_consts.svh
// Operation
// - MSB driven out at chip select fall
// - Later bits shifted after clock falling edge
// - Output released once chip select rises
// - Both sides use polarity 1, phase 1
// - Input bits captured on clock rising edge
`ifndef SPI_SLAVE_CONSTS_SVH
`define SPI_SLAVE_CONSTS_SVH
// -------------------------------------------------------------
// Link constants
// -------------------------------------------------------------
`define WORD_BITS 16
`define FAST_MODE_MAX_SETTING 8'h07
`define CLK_PERIOD_NS 10
`define FAST_FRAME_SPACING_US 40
`define NORMAL_FRAME_SPACING_US 100
`define FAST_FRAME_SPACING_CYC \
  ((`FAST_FRAME_SPACING_US*1000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define NORMAL_FRAME_SPACING_CYC \
  ((`NORMAL_FRAME_SPACING_US*1000+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define SYNC_RESET 3'h7
`endif

// file: rtl/spi_slave_pkg.sv
`include "spi_slave_consts.svh"
package spi_slave_pkg;
  // Serial pins, before and after synchronisation
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } spi_pins_s;
  // Word handed to the user side
  typedef struct packed {
    logic [`WORD_BITS-1:0] data;
    logic frame_short;
  } rx_word_s;
endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_consts.svh"
module pin_sync
  import spi_slave_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire spi_pins_s i_pins,
  output spi_pins_s o_pins
);
  // -------------------------------------------------------------
  // Two flops per pin
  // -------------------------------------------------------------
  logic [2:0] meta_q; // First stage, read only by second stage
  logic [2:0] sync_q; // Second stage
  // Synchroniser chain
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_q <= `SYNC_RESET;
      sync_q <= `SYNC_RESET;
    end
    else
    begin
      meta_q <= i_pins;
      sync_q <= meta_q;
    end
  end
  assign o_pins = sync_q;
endmodule
`default_nettype wire

// file: rtl/spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_consts.svh"
module spi_slave
  import spi_slave_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic [7:0] i_sample_period_setting,
  input wire logic [`WORD_BITS-1:0] i_tx_data,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_tx_load,
  output logic o_rx_valid,
  output logic [`WORD_BITS-1:0] o_rx_data,
  output logic o_rx_frame_short
);
  // -------------------------------------------------------------
  // Pin synchronisation and edge detection
  // -------------------------------------------------------------
  spi_pins_s raw_pins; // Pins as they arrive
  spi_pins_s pins; // Pins after two flops
  logic sclk_prev_q; // Clock level one cycle back
  logic cs_prev_q; // Select level one cycle back
  logic sclk_rise; // Rising clock edge seen
  logic sclk_fall; // Falling clock edge seen
  logic cs_fall; // Frame start
  logic cs_rise; // Frame end
  assign raw_pins = '{sclk: i_sclk, cs_n: i_cs_n, din: i_din};
  pin_sync u_sync
  (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_pins(raw_pins),
    .o_pins(pins)
  );
  // Previous levels for edge finding
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sclk_prev_q <= 1'h1;
      cs_prev_q <= 1'h1;
    end
    else
    begin
      sclk_prev_q <= pins.sclk;
      cs_prev_q <= pins.cs_n;
    end
  end
  // Mode 3: edges only count inside a frame
  assign sclk_rise = !pins.cs_n && pins.sclk && !sclk_prev_q;
  assign sclk_fall = !pins.cs_n && !pins.sclk && sclk_prev_q;
  assign cs_fall = !pins.cs_n && cs_prev_q;
  assign cs_rise = pins.cs_n && !cs_prev_q;
  // -------------------------------------------------------------
  // Frame state
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_FRAME = 2'b10
  } frame_state_e;
  frame_state_e state_q; // Frame state
  // Idle until select falls, frame until it rises
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (cs_fall)
            state_q <= ST_FRAME;
        ST_FRAME:
          if (cs_rise)
            state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end
  // -------------------------------------------------------------
  // Transmit shifter
  // -------------------------------------------------------------
  logic [`WORD_BITS-1:0] tx_q; // Bits still to send, MSB first
  logic dout_q; // Output bit register
  logic oe_q; // Output driven
  // Load at select fall, shift after each falling clock
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tx_q <= '0;
      dout_q <= 1'h0;
    end
    else if (cs_fall)
    begin
      // MSB kept in the shifter: the first falling edge leaves it standing
      tx_q <= i_tx_data;
      dout_q <= i_tx_data[`WORD_BITS-1];
    end
    else if (sclk_fall)
    begin
      tx_q <= {tx_q[`WORD_BITS-2:0], 1'h0};
      dout_q <= tx_q[`WORD_BITS-1];
    end
  end
  // Drive only inside a frame
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      oe_q <= 1'h0;
    else if (cs_fall)
      oe_q <= 1'h1;
    else if (cs_rise)
      oe_q <= 1'h0;
  end
  assign o_dout = dout_q;
  assign o_dout_oe = oe_q;
  assign o_tx_load = cs_fall;
  // -------------------------------------------------------------
  // Receive shifter
  // -------------------------------------------------------------
  logic [`WORD_BITS-1:0] rx_q; // Bits taken so far
  logic [4:0] rx_cnt_q; // Count of bits taken
  logic rx_valid_q; // One-cycle word strobe
  rx_word_s rx_out_q; // Last complete word
  // Sample input on rising clock
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_q <= '0;
      rx_cnt_q <= 5'h00;
    end
    else if (cs_fall)
      rx_cnt_q <= 5'h00;
    else if (sclk_rise)
    begin
      rx_q <= {rx_q[`WORD_BITS-2:0], pins.din};
      if (rx_cnt_q == 5'(`WORD_BITS - 1))
        rx_cnt_q <= 5'h00;
      else
        rx_cnt_q <= rx_cnt_q + 5'h01;
    end
  end
  // -------------------------------------------------------------
  // Frame spacing monitor
  // -------------------------------------------------------------
  logic [13:0] gap_q; // Cycles since last frame start
  logic [13:0] gap_min; // Least spacing for current mode
  logic gap_ok_q; // Spacing since last start was met
  assign gap_min = (i_sample_period_setting <= `FAST_MODE_MAX_SETTING)
    ? 14'(`FAST_FRAME_SPACING_CYC)
    : 14'(`NORMAL_FRAME_SPACING_CYC);
  // Count from each select fall, saturating
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      gap_q <= 14'h3fff;
      gap_ok_q <= 1'h1;
    end
    else if (cs_fall)
    begin
      // Starts at one: the load edge itself is one cycle of spacing
      gap_q <= 14'h0001;
      gap_ok_q <= (gap_q >= gap_min);
    end
    else if (gap_q != 14'h3fff)
      gap_q <= gap_q + 14'h0001;
  end
  // Word out after the last rising edge
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_valid_q <= 1'h0;
      rx_out_q <= '0;
    end
    else
    begin
      rx_valid_q <= sclk_rise && (rx_cnt_q == 5'(`WORD_BITS - 1));
      if (sclk_rise && (rx_cnt_q == 5'(`WORD_BITS - 1)))
        rx_out_q <= '{data: {rx_q[`WORD_BITS-2:0], pins.din},
                      frame_short: !gap_ok_q};
    end
  end
  assign o_rx_valid = rx_valid_q;
  assign o_rx_data = rx_out_q.data;
  assign o_rx_frame_short = rx_out_q.frame_short;
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  property p_msb_first;
    @(posedge i_clk) disable iff (!i_nrst)
    cs_fall |=> (o_dout == $past(i_tx_data[`WORD_BITS-1])) && o_dout_oe;
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("MSB not driven at select fall");
  property p_shift_on_fall;
    @(posedge i_clk) disable iff (!i_nrst)
    (sclk_fall && !cs_fall) |=> (o_dout == $past(tx_q[`WORD_BITS-1]));
  endproperty
  a_shift_on_fall: assert property (p_shift_on_fall)
    else $error("Output bit not shifted on falling clock");
  property p_hold_on_rise;
    @(posedge i_clk) disable iff (!i_nrst)
    (!cs_fall && !sclk_fall) |=> $stable(o_dout);
  endproperty
  a_hold_on_rise: assert property (p_hold_on_rise)
    else $error("Output bit changed without falling clock");
  property p_release;
    @(posedge i_clk) disable iff (!i_nrst)
    cs_rise |=> !o_dout_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("Output still driven after select rise");
  property p_idle_released;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_q == ST_IDLE && !cs_fall) |=> !o_dout_oe;
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("Output driven outside frame");
  property p_capture;
    @(posedge i_clk) disable iff (!i_nrst)
    (sclk_rise && !cs_fall) |=> (rx_q[0] == $past(pins.din));
  endproperty
  a_capture: assert property (p_capture)
    else $error("Input bit not captured on rising clock");
  property p_word_strobe;
    @(posedge i_clk) disable iff (!i_nrst)
    o_rx_valid |=> !o_rx_valid;
  endproperty
  a_word_strobe: assert property (p_word_strobe)
    else $error("Word strobe longer than one cycle");
  property p_no_edge_idle;
    @(posedge i_clk) disable iff (!i_nrst)
    pins.cs_n |-> !sclk_rise && !sclk_fall;
  endproperty
  a_no_edge_idle: assert property (p_no_edge_idle)
    else $error("Clock edge counted outside frame");
  property p_gap_fast;
    @(posedge i_clk) disable iff (!i_nrst)
    (cs_fall && i_sample_period_setting <= `FAST_MODE_MAX_SETTING)
      |=> (gap_ok_q == ($past(gap_q) >= 14'(`FAST_FRAME_SPACING_CYC)));
  endproperty
  a_gap_fast: assert property (p_gap_fast)
    else $error("Fast mode spacing judged wrongly");
  property p_gap_normal;
    @(posedge i_clk) disable iff (!i_nrst)
    (cs_fall && i_sample_period_setting > `FAST_MODE_MAX_SETTING)
      |=> (gap_ok_q == ($past(gap_q) >= 14'(`NORMAL_FRAME_SPACING_CYC)));
  endproperty
  a_gap_normal: assert property (p_gap_normal)
    else $error("Normal mode spacing judged wrongly");
endmodule
`default_nettype wire

// file: dv/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------
// Serial host model: 125 ns link clock, mode 3 framing
// ---------------------------------------------------------
module spi_host_model
(
  input wire logic i_dout,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din
);
  // Idle: select high, clock parked high
  initial
  begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // One 16-bit frame, MSB first; m is the line before any edge
  task automatic frame(input logic [15:0] w, output logic [15:0] r,
    output logic m);
    o_cs_n = 1'b0;
    #100;
    m = i_dout;
    for (int i = 15; i >= 0; i--)
    begin
      // Data changes on the fall, is sampled on the rise
      o_sclk = 1'b0;
      o_din = w[i];
      #62.5;
      o_sclk = 1'b1;
      r[i] = i_dout;
      #62.5;
    end
    // Hold select past the last rise, then scramble the data line
    #100;
    o_cs_n = 1'b1;
    o_din = ~o_din;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_inertial_sensor_spi_slave_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_consts.svh"
module tb_inertial_sensor_spi_slave_timing;
  // ---------------------------------------------------------
  // Signals
  // ---------------------------------------------------------
  logic clk = 1'b0;
  logic nrst, sclk, cs_n, din, dout, dout_oe, tx_load, rx_valid, rx_short;
  logic msb, gshort;
  logic [7:0] setting;
  logic [15:0] tx_data, rx_data, got, hrx, w, vcnt, lcnt;
  wire dout_line;
  integer mismatches, checked, seed;
  // Released line shows the inverse, so a late drive is caught
  assign dout_line = dout_oe ? dout : ~dout;
  // Clock
  always #5 clk = ~clk;
  // ---------------------------------------------------------
  // Design and host
  // ---------------------------------------------------------
  spi_slave u_dut (.i_clk(clk), .i_nrst(nrst), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_din(din), .i_sample_period_setting(setting),
    .i_tx_data(tx_data), .o_dout(dout), .o_dout_oe(dout_oe),
    .o_tx_load(tx_load), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_frame_short(rx_short));
  spi_host_model u_host (.i_dout(dout_line), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_din(din));
  // Capture words and load strobes mid-cycle, where they are settled
  always @(negedge clk)
  begin
    if (rx_valid === 1'b1)
    begin
      got <= rx_data;
      gshort <= rx_short;
      vcnt <= vcnt + 16'h1;
    end
    if (tx_load === 1'b1)
      lcnt <= lcnt + 16'h1;
  end
  // ---------------------------------------------------------
  // Compare and finish
  // ---------------------------------------------------------
  task cmp16(input logic [15:0] a, input logic [15:0] e);
    checked++;
    if (a !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task cmp1(input logic a, input logic e);
    checked++;
    if (a !== e)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task finish_test;
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One frame after a gap of g cycles; es is the expected flag
  task run(input logic [7:0] s, input int g, input logic es,
    input logic chk);
    @(posedge clk);
    #1 setting = s;
    repeat (g) @(posedge clk);
    #1 tx_data = 16'($random(seed));
    w = 16'($random(seed));
    vcnt = 16'h0;
    lcnt = 16'h0;
    u_host.frame(w, hrx, msb);
    repeat (10) @(posedge clk);
    cmp1(msb, tx_data[15]);
    cmp16(lcnt, 16'h1);
    cmp16(hrx, tx_data);
    cmp16(got, w);
    cmp16(vcnt, 16'h1);
    cmp1(dout_oe, 1'b0);
    if (chk)
      cmp1(gshort, es);
  endtask
  // ---------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------
  initial
  begin
    seed = 32'h85b6;
    mismatches = 0;
    checked = 0;
    nrst = 1'b0;
    setting = 8'h00;
    tx_data = 16'h0;
    vcnt = 16'h0;
    lcnt = 16'h0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    run(8'h00, 0, 1'b0, 1'b0);
    // Mode boundaries, frames too close and far enough apart
    run(8'h07, 100, 1'b1, 1'b1);
    run(8'h07, 4000, 1'b0, 1'b1);
    run(8'h08, 4000, 1'b1, 1'b1);
    run(8'h08, 10000, 1'b0, 1'b1);
    run({5'h00, 3'($random(seed))}, 4000, 1'b0, 1'b1);
    // Back-to-back frames with random settings and data
    for (int k = 0; k < 8; k++)
      run(8'($random(seed)), 0, 1'b1, 1'b1);
    // Reset in mid-run: outputs clear, spacing monitor starts afresh
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    cmp1(dout_oe, 1'b0);
    cmp16(rx_data, 16'h0);
    cmp1(rx_short, 1'b0);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    run(8'h08, 0, 1'b0, 1'b1);
    finish_test;
  end
  initial
  begin
    #500000;
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
